//--- core/bus_pkg.sv
// Purpose: Shared types and constants for the local bus cycle engine.
// Assumes: core_clk is the double-rate clock; one bus state is two periods.
// Notes:   Cycle-definition encodings are fixed here and used by the engine.
package bus_pkg;

    // Clock and bus-state timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int CLKS_PER_STATE  = 2;
    localparam int PHASE_W         = $clog2(CLKS_PER_STATE);

    // Byte-lane masks (active high inside the engine; LANES_OFF_N is the active-low all-off pin value)
    localparam logic [3:0] LANES_LOW   = 4'h3;
    localparam logic [3:0] LANES_UPPER = 4'hc;
    localparam logic [3:0] LANES_OFF_N = 4'hf;

    // Operand masks per size, before shifting by the byte offset
    localparam logic [3:0] MASK_BYTE  = 4'h1;
    localparam logic [3:0] MASK_WORD  = 4'h3;
    localparam logic [3:0] MASK_DWORD = 4'hf;

    // Definition encodings {mem_io_sel, data_not_control, write_not_read}
    localparam logic [2:0] DEF_INT_ACK = 3'h0;
    localparam logic [2:0] DEF_IO_RD   = 3'h2;
    localparam logic [2:0] DEF_IO_WR   = 3'h3;
    localparam logic [2:0] DEF_HALT    = 3'h5;
    localparam logic [2:0] DEF_MEM_RD  = 3'h6;
    localparam logic [2:0] DEF_MEM_WR  = 3'h7;

    typedef enum logic [2:0] {
        k_mem_rd, k_mem_rd_lock, k_mem_wr, k_mem_wr_lock,
        k_io_rd, k_io_wr, k_int_ack, k_halt
    } cycle_kind_t;

    typedef enum logic [1:0] {
        sz_byte  = 2'h0,
        sz_word  = 2'h1,
        sz_dword = 2'h2
    } op_size_t;

    typedef enum logic [3:0] {
        st_idle = 4'b0001,
        st_addr = 4'b0010,
        st_data = 4'b0100,
        st_hold = 4'b1000
    } bus_state_t;

endpackage : bus_pkg

//--- core/bus_state_timer.sv
// Purpose: Marks the last double-rate clock of each bus state.
// Assumes: Free-running count; bus states begin right after reset.
// Notes:   Frozen while ce is low, like the rest of the engine.
`timescale 1ns/1ps
module bus_state_timer
    import bus_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic ce,
    output logic      state_end
);
    logic [PHASE_W-1:0] phase;
    logic [PHASE_W-1:0] next_phase;

    // Wrap at the last clock of a bus state
    always_comb begin
        state_end  = (phase == PHASE_W'(CLKS_PER_STATE - 1));
        next_phase = state_end ? '0 : phase + PHASE_W'(1);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phase <= '0;
        end else if (ce) begin
            phase <= next_phase;
        end
    end
endmodule : bus_state_timer

//--- core/cpu_bus_cycle_and_halfwidth_adapter.sv
// Purpose: Local bus cycle engine with dynamic 32/16-bit port sizing.
// Assumes: Inputs are synchronous to core_clk; requests hold until taken.
// Notes:   No address pipelining; one request is in flight at a time.
// Function
// R01: Separate 32-bit two-way data bus.
// R02: 30 dword address lines plus four lane selects.
// R03: Three definition signals with address each cycle.
// R04: Address strobe marks each new cycle definition.
// R05: Eight bus cycle types supported.
// R06: Partner reports port width; all types both widths.
// R07: Idle after termination with no new strobe.
// R08: Hold state shown on hold granted output.
// R09: Bus state is two double-rate clocks.
// R10: Minimum cycle is address then data state.
// R11: Cycle stays open until acknowledge sampled.
// R12: Negated acknowledge repeats the data state.
// R13: Adapter drives word address bit from lanes; the engine has no such output, bus_target_model decodes a1 from the lanes.
// R14: Adapter derives upper and lower byte enables; the engine has no such outputs, bus_target_model decodes en from the lanes.
// R15: 32-bit port splits misaligned, high part first.
// R16: 16-bit port splits low-order first, up to three.
// R17: Any address reachable in two states.
// R18: Half-width select matters only with upper lanes.
// R19: Second half cycle uses lower half, lanes 0-1 off.
// R20: Acknowledge sampled at data state end; read latched.
// R21: Reset leaves bus idle with strobe negated.
`timescale 1ns/1ps
module cpu_bus_cycle_and_halfwidth_adapter
    import bus_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire logic          req_valid,
    input  wire bus_pkg::cycle_kind_t req_kind,
    input  wire bus_pkg::op_size_t    req_size,
    input  wire logic [31:0]   req_addr,
    input  wire logic [31:0]   req_wdata,
    output logic               req_taken,
    output logic               done,
    output logic [31:0]        rdata,
    input  wire logic          hold_req,
    output logic               hold_granted,
    output logic [29:0]        dword_address_lines,
    output logic [3:0]         byte_lane_selects_n,
    output logic               mem_io_sel,
    output logic               data_not_control,
    output logic               write_not_read,
    output logic               bus_lock_n,
    output logic               address_strobe_out_n,
    output logic [31:0]        data_out,
    output logic               data_oe,
    input  wire logic [31:0]   data_in,
    input  wire logic          cycle_ack_n,
    input  wire logic          half_width_port_select_n
);
    import bus_pkg::*;

    bus_state_t  state, next_state;
    cycle_kind_t kind, next_kind;
    logic [29:0] base, next_base;
    logic [1:0]  offset, next_offset;
    logic        piece, next_piece;
    logic        half, next_half;
    logic        two, next_two;
    logic [3:0]  mask, next_mask;
    logic [3:0]  mask2, next_mask2;
    logic [63:0] wbuf, next_wbuf;
    logic [63:0] rbuf, next_rbuf;
    logic        state_end;
    logic        sp_two;
    logic [3:0]  sp_first, sp_second;
    logic        load, half16, split_need, high_piece;
    logic [2:0]  def;
    logic [31:0] wword;
    logic [31:0] next_rdata, next_data_out;
    logic [29:0] next_dword;
    logic [3:0]  next_lanes_n;
    logic        next_taken, next_done, next_strobe_n, next_oe, next_lock_n;
    logic        next_mio, next_dc, next_wr, next_hold;

    bus_state_timer u_timer (
        .core_clk  (core_clk),
        .rst       (rst),
        .ce        (ce),
        .state_end (state_end)       // R09
    );

    transfer_splitter u_split (
        .offset      (req_addr[1:0]),
        .size        (req_size),
        .two_pieces  (sp_two),
        .first_mask  (sp_first),
        .second_mask (sp_second)
    );

    // Width select only counts when upper lanes take part
    assign half16     = !half_width_port_select_n && (mask[2] || mask[3]); // R18 R06
    assign split_need = (mask[0] || mask[1]) && (mask[2] || mask[3]);
    assign high_piece = two && !piece;

    // Map the cycle type onto the three definition signals
    always_comb begin
        case (kind)
            k_mem_rd, k_mem_rd_lock: def = DEF_MEM_RD; // R05
            k_mem_wr, k_mem_wr_lock: def = DEF_MEM_WR;
            k_io_rd:                 def = DEF_IO_RD;
            k_io_wr:                 def = DEF_IO_WR;
            k_int_ack:               def = DEF_INT_ACK;
            default:                 def = DEF_HALT;
        endcase
    end

    // Bus sequencing: every transition waits for the end of a bus state
    always_comb begin
        next_state  = state;
        next_kind   = kind;
        next_base   = base;
        next_offset = offset;
        next_piece  = piece;
        next_half   = half;
        next_two    = two;
        next_mask   = mask;
        next_mask2  = mask2;
        next_wbuf   = wbuf;
        next_rbuf   = rbuf;
        next_rdata  = rdata;
        next_taken  = 1'b0;
        next_done   = 1'b0;
        load        = 1'b0;
        if (state_end) begin
            case (state)
                st_idle: begin
                    if (hold_req) begin
                        next_state = st_hold;
                    end else if (req_valid) begin
                        load = 1'b1;
                    end
                end
                st_hold: begin
                    if (!hold_req) begin
                        next_state = st_idle;
                    end
                end
                st_addr: begin
                    next_state = st_data; // R10 R17
                end
                st_data: begin
                    // No ack: stay in the data state, which adds a wait state
                    if (!cycle_ack_n) begin // R11 R12 R20
                        for (int k = 0; k < 4; k++) begin
                            if (mask[k] && !(half16 && split_need && k >= 2)) begin
                                next_rbuf[(high_piece ? k + 4 : k) * 8 +: 8] =
                                    (half16 && k >= 2) ? data_in[(k - 2) * 8 +: 8]
                                                       : data_in[k * 8 +: 8]; // R18 R20
                            end
                        end
                        if (half16 && split_need && !half) begin
                            next_half  = 1'b1; // R16
                            next_mask  = mask & LANES_UPPER; // R19
                            next_state = st_addr;
                        end else if (high_piece) begin
                            next_piece = 1'b1; // R15
                            next_half  = 1'b0;
                            next_mask  = mask2;
                            next_state = st_addr;
                        end else begin
                            next_done  = 1'b1;
                            next_rdata = 32'(next_rbuf >> {offset, 3'h0});
                            next_state = st_idle; // R07
                            if (hold_req) begin
                                next_state = st_hold;
                            end else if (req_valid) begin
                                load = 1'b1; // R10
                            end
                        end
                    end
                end
                default: begin
                    next_state = st_idle;
                end
            endcase
        end
        if (load) begin
            next_state  = st_addr;
            next_taken  = 1'b1;
            next_kind   = req_kind;
            next_base   = req_addr[31:2];
            next_offset = req_addr[1:0];
            next_piece  = 1'b0;
            next_half   = 1'b0;
            next_two    = sp_two;
            next_mask   = sp_first;
            next_mask2  = sp_second;
            next_wbuf   = {32'h0, req_wdata} << {req_addr[1:0], 3'h0};
            next_rbuf   = '0;
        end
    end

    // Pin values for the coming bus state, registered below
    always_comb begin
        next_strobe_n = (next_state != st_addr); // R04 R21
        next_hold     = (next_state == st_hold); // R08
        next_dword    = next_base + 30'((next_two && !next_piece) ? 1 : 0); // R02
        next_lanes_n  = byte_lane_selects_n;
        next_mio      = mem_io_sel;
        next_dc       = data_not_control;
        next_wr       = write_not_read;
        if (next_state == st_addr) begin
            next_lanes_n = ~next_mask; // R02 R19
            next_mio     = def[2];   // R03
            next_dc      = def[1];
            next_wr      = def[0];
            if (load) begin
                next_dword = next_base + 30'(next_two ? 1 : 0);
            end
        end else if (next_state != st_data) begin
            next_lanes_n = LANES_OFF_N;
        end
        if (load) begin
            case (req_kind)
                k_mem_rd, k_mem_rd_lock: {next_mio, next_dc, next_wr} = DEF_MEM_RD;
                k_mem_wr, k_mem_wr_lock: {next_mio, next_dc, next_wr} = DEF_MEM_WR;
                k_io_rd:   {next_mio, next_dc, next_wr} = DEF_IO_RD;
                k_io_wr:   {next_mio, next_dc, next_wr} = DEF_IO_WR;
                k_int_ack: {next_mio, next_dc, next_wr} = DEF_INT_ACK;
                default:   {next_mio, next_dc, next_wr} = DEF_HALT;
            endcase
        end
        next_lock_n = !((next_kind == k_mem_rd_lock || next_kind == k_mem_wr_lock)
                        && (next_state == st_addr || next_state == st_data));
        // Upper-only lanes also ride the low half, so 16-bit ports need no action
        wword         = (next_two && !next_piece) ? next_wbuf[63:32] : next_wbuf[31:0];
        next_data_out = (next_mask[1:0] == 2'h0) ? {wword[31:16], wword[31:16]}
                                                 : wword; // R19 R01
        next_oe       = next_wr && (next_state == st_addr || next_state == st_data);
    end

    // Everything freezes while ce is low
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state                <= st_idle; // R21
            kind                 <= k_mem_rd;
            base                 <= '0;
            offset               <= '0;
            piece                <= 1'b0;
            half                 <= 1'b0;
            two                  <= 1'b0;
            mask                 <= '0;
            mask2                <= '0;
            wbuf                 <= '0;
            rbuf                 <= '0;
            rdata                <= '0;
            req_taken            <= 1'b0;
            done                 <= 1'b0;
            hold_granted         <= 1'b0;
            dword_address_lines  <= '0;
            byte_lane_selects_n  <= LANES_OFF_N;
            mem_io_sel           <= 1'b0;
            data_not_control     <= 1'b0;
            write_not_read       <= 1'b0;
            bus_lock_n           <= 1'b1;
            address_strobe_out_n <= 1'b1;
            data_out             <= '0;
            data_oe              <= 1'b0;
        end else if (ce) begin
            state                <= next_state;
            kind                 <= next_kind;
            base                 <= next_base;
            offset               <= next_offset;
            piece                <= next_piece;
            half                 <= next_half;
            two                  <= next_two;
            mask                 <= next_mask;
            mask2                <= next_mask2;
            wbuf                 <= next_wbuf;
            rbuf                 <= next_rbuf;
            rdata                <= next_rdata;
            req_taken            <= next_taken;
            done                 <= next_done;
            hold_granted         <= next_hold;
            dword_address_lines  <= next_dword;
            byte_lane_selects_n  <= next_lanes_n;
            mem_io_sel           <= next_mio;
            data_not_control     <= next_dc;
            write_not_read       <= next_wr;
            bus_lock_n           <= next_lock_n;
            address_strobe_out_n <= next_strobe_n;
            data_out             <= next_data_out;
            data_oe              <= next_oe;
        end
    end

    // Checks on the bus sequencing
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_strobe_addr_state: assert property ( // R04
        address_strobe_out_n == (state != st_addr))
        else $error("strobe does not match address state");
    a_wait_state_repeat: assert property ( // R12
        (state == st_data && state_end && ce && cycle_ack_n) |=> state == st_data)
        else $error("data state left without acknowledge");
    a_ack_ends_data: assert property ( // R11
        (state == st_data && state_end && ce && !cycle_ack_n) |=> state != st_data)
        else $error("acknowledged data state not ended");
    a_addr_two_clocks: assert property ( // R09
        (ce && state == st_addr && $past(state) != st_addr) |=> state == st_addr)
        else $error("address state shorter than two clocks");
    a_hold_no_strobe: assert property ( // R08
        hold_granted |-> (state == st_hold && address_strobe_out_n && !data_oe))
        else $error("hold granted while bus active");
    a_split_low_off: assert property ( // R19
        (state == st_addr && half) |-> byte_lane_selects_n[1:0] == 2'h3)
        else $error("low lanes selected in second half cycle");
    a_lanes_active: assert property ( // R02
        (state == st_addr) |-> byte_lane_selects_n != LANES_OFF_N)
        else $error("address state with no lane selected");
    a_idle_quiet: assert property ( // R07
        (state == st_idle) |-> (address_strobe_out_n && !data_oe && bus_lock_n))
        else $error("idle bus still driven");
    a_done_single: assert property ( // R20
        (done && ce) |=> !done)
        else $error("done longer than one cycle");

    c_half_split: cover property (state == st_addr && half);
    c_wait_state: cover property (state == st_data && state_end && cycle_ack_n);
    c_back_to_back: cover property (done && state == st_addr);
    c_hold_entered: cover property (hold_granted);

endmodule : cpu_bus_cycle_and_halfwidth_adapter

//--- core/transfer_splitter.sv
// Purpose: Splits an operand into one or two dword-aligned pieces.
// Assumes: Size is byte, word or dword; offset is the low address bits.
// Notes:   Pure logic; the high-order piece is always issued first.
`timescale 1ns/1ps
module transfer_splitter
    import bus_pkg::*;
(
    input  wire logic [1:0] offset,
    input  wire op_size_t   size,
    output logic            two_pieces,
    output logic [3:0]      first_mask,
    output logic [3:0]      second_mask
);
    logic [3:0] base;
    logic [7:0] span;

    // Lanes of the operand across this dword and the next one
    always_comb begin
        case (size)
            sz_byte:  base = MASK_BYTE;
            sz_word:  base = MASK_WORD;
            default:  base = MASK_DWORD;
        endcase
        span        = {4'h0, base} << offset;
        two_pieces  = |span[7:4];
        first_mask  = two_pieces ? span[7:4] : span[3:0]; // R15
        second_mask = span[3:0];
    end
endmodule : transfer_splitter

//--- dv/bus_target_model.sv
// Purpose: Memory or I/O target behind the local bus, with a 16-bit region and wait states.
// Assumes: Strobe low marks the address state; ack is sampled on odd counts of the data phase.
// Notes:   Addresses with bit 11 set behave as a 16-bit port; other lines toggle when idle.
`timescale 1ns/1ps
module bus_target_model (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  waits,
    input  wire logic [29:0] dword_address_lines,
    input  wire logic [3:0]  byte_lane_selects_n,
    input  wire logic        address_strobe_out_n,
    input  wire logic        write_not_read,
    input  wire logic [31:0] data_out,
    output logic [31:0]      data_in,
    output logic             cycle_ack_n,
    output logic             half_width_port_select_n
);
    logic [31:0] mem [16];
    logic [4:0]  n;
    logic        busy;
    logic        junk = 1'b0;
    logic [3:0]  sel, en, idx;
    logic        narrow;
    logic        a1;

    // Lane decode for the 16-bit array
    assign sel    = ~byte_lane_selects_n;
    assign idx    = dword_address_lines[3:0];
    assign narrow = dword_address_lines[9];
    assign a1     = !(sel[0] || sel[1]);
    assign en     = a1 ? {sel[3], sel[2], 2'b00} : {2'b00, sel[1], sel[0]};

    // Ack only in the last clock of the chosen data state
    assign cycle_ack_n = !(busy && address_strobe_out_n && n == {waits, 1'b1});
    assign half_width_port_select_n = !(busy && narrow);

    // Count clocks of the data phase since the strobe
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            n    <= 5'h0;
        end else if (!address_strobe_out_n) begin
            busy <= 1'b1;
            n    <= 5'h0;
        end else if (busy) begin
            busy <= cycle_ack_n;
            n    <= n + 5'h1;
        end
    end

    // Released lines toggle so a stale value never passes for data
    always_comb begin
        if (!(busy && address_strobe_out_n)) begin
            data_in = {32{junk}};
        end else if (narrow) begin
            data_in = {{16{junk}}, a1 ? mem[idx][31:16] : mem[idx][15:0]};
        end else begin
            data_in = mem[idx];
        end
    end

    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 32'h0;
        end
    end

    // A 16-bit port only sees the lower data half
    always @(posedge core_clk) begin
        junk <= ~junk;
        if (busy && !cycle_ack_n && write_not_read) begin
            for (int b = 0; b < 4; b++) begin
                if (narrow ? en[b] : sel[b]) begin
                    mem[idx][8*b +: 8] <= narrow ? data_out[8*(b%2) +: 8] : data_out[8*b +: 8];
                end
            end
        end
    end
endmodule : bus_target_model

//--- dv/cpu_bus_cycle_and_halfwidth_adapter_tb_top.sv
// Purpose: Self-checking bench for the bus cycle engine against the target model.
// Assumes: One request in flight; expectations come from sizes, offsets and wait counts.
// Notes:   Each piece costs four clocks plus two per wait state.
`timescale 1ns/1ps
module cpu_bus_cycle_and_halfwidth_adapter_tb_top;
    import bus_pkg::*;
    logic        core_clk, rst, req_valid, req_taken, done, hold_req, hold_granted;
    logic        mem_io_sel, data_not_control, write_not_read, bus_lock_n;
    logic        address_strobe_out_n, data_oe, cycle_ack_n, half_width_port_select_n;
    cycle_kind_t req_kind;
    op_size_t    req_size;
    logic [31:0] req_addr, req_wdata, rdata, data_out, data_in;
    logic [29:0] dword_address_lines;
    logic [3:0]  byte_lane_selects_n, waits;
    logic [2:0]  exp_def;
    logic        exp_lock, mon_on;
    int          err_total, checks_done, strobes, lat, pieces;
    // {size, offset, 16-bit region, pieces}
    localparam logic [7:0] TBL [15] = '{8'h01, 8'h72, 8'h92, 8'ha2, 8'hb2, 8'h61, 8'h81,
        8'h5a, 8'h69, 8'h7a, 8'h8a, 8'haa, 8'h9b, 8'hbb, 8'h39};
    localparam logic [2:0] DEFS [8] = '{DEF_MEM_RD, DEF_MEM_RD, DEF_MEM_WR, DEF_MEM_WR,
        DEF_IO_RD, DEF_IO_WR, DEF_INT_ACK, DEF_HALT};

    cpu_bus_cycle_and_halfwidth_adapter dut_u (.core_clk(core_clk), .rst(rst), .ce(1'b1),
        .req_valid(req_valid), .req_kind(req_kind), .req_size(req_size), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_taken(req_taken), .done(done), .rdata(rdata),
        .hold_req(hold_req), .hold_granted(hold_granted),
        .dword_address_lines(dword_address_lines), .byte_lane_selects_n(byte_lane_selects_n),
        .mem_io_sel(mem_io_sel), .data_not_control(data_not_control),
        .write_not_read(write_not_read), .bus_lock_n(bus_lock_n),
        .address_strobe_out_n(address_strobe_out_n), .data_out(data_out), .data_oe(data_oe),
        .data_in(data_in), .cycle_ack_n(cycle_ack_n),
        .half_width_port_select_n(half_width_port_select_n));

    bus_target_model target_u (.core_clk(core_clk), .rst(rst), .waits(waits),
        .dword_address_lines(dword_address_lines), .byte_lane_selects_n(byte_lane_selects_n),
        .address_strobe_out_n(address_strobe_out_n), .write_not_read(write_not_read),
        .data_out(data_out), .data_in(data_in), .cycle_ack_n(cycle_ack_n),
        .half_width_port_select_n(half_width_port_select_n));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    // Strobe clocks are counted here; cycle definition judged while enabled
    always @(posedge core_clk) begin
        if (address_strobe_out_n === 1'b0) begin
            strobes++;
            if (mon_on) begin
                check("definition", {29'h0, mem_io_sel, data_not_control, write_not_read},
                      {29'h0, exp_def});
                check("drive", {31'h0, data_oe}, {31'h0, exp_def[0]});
                check("lock", {31'h0, bus_lock_n}, {31'h0, exp_lock});
                check("address", {2'h0, dword_address_lines}, 32'h8);
                check("lanes", {28'h0, byte_lane_selects_n}, 32'he);
            end
        end
    end

    // One operand through the request port; lat counts clocks from taken to done
    task automatic op(input cycle_kind_t k, input op_size_t s, input logic [31:0] a,
                      input logic [31:0] w, output logic [31:0] r);
        int t;
        int s0;
        s0 = strobes;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_kind  <= k;
        req_size  <= s;
        req_addr  <= a;
        req_wdata <= w;
        t = 0;
        do begin
            @(negedge core_clk);
            t++;
        end while (req_taken !== 1'b1 && t < 40);
        @(posedge core_clk);
        req_valid <= 1'b0;
        lat = 0;
        do begin
            @(negedge core_clk);
            lat++;
        end while (done !== 1'b1 && lat < 80);
        if (t >= 40 || lat >= 80) begin
            err_total++;
            final_report();
        end
        r = rdata;
        pieces = (strobes - s0) / 2;
    endtask : op

    task automatic t_reset();
        repeat (3) @(negedge core_clk);
        check("strobe idle", {31'h0, address_strobe_out_n}, 32'h1);
        check("lanes idle", {28'h0, byte_lane_selects_n}, 32'hf);
        check("hold idle", {31'h0, hold_granted}, 32'h0);
        check("drive idle", {31'h0, data_oe}, 32'h0);
        $display("test reset done");
    endtask : t_reset

    // Each wait state stretches a cycle by one bus state
    task automatic t_waits();
        logic [31:0] r;
        for (int w = 0; w < 4; w++) begin
            @(posedge core_clk);
            waits <= 4'(w);
            op(k_mem_wr, sz_dword, 32'h40, 32'h1234_5670 + 32'(w), r);
            check("write latency", 32'(lat), 32'(4 + 2 * w));
            op(k_mem_rd, sz_dword, 32'h40, 32'h0, r);
            check("read latency", 32'(lat), 32'(4 + 2 * w));
            check("read data", r, 32'h1234_5670 + 32'(w));
        end
        @(posedge core_clk);
        waits <= 4'h0;
        $display("test waits done");
    endtask : t_waits

    // Every split case on both port widths, written then read back
    task automatic t_split();
        logic [31:0] r, a, w, m;
        logic [7:0]  e;
        for (int i = 0; i < 15; i++) begin
            e = TBL[i];
            a = (e[3] ? 32'h800 : 32'h0) + 32'((i % 8) * 8) + 32'(e[5:4]);
            w = 32'hc3a5_9600 | 32'(i);
            m = e[7:6] == 2'h0 ? 32'hff : e[7:6] == 2'h1 ? 32'hffff : 32'hffff_ffff;
            op(k_mem_wr, op_size_t'(e[7:6]), a, w, r);
            check("write pieces", 32'(pieces), 32'(e[2:0]));
            op(k_mem_rd, op_size_t'(e[7:6]), a, 32'h0, r);
            check("read pieces", 32'(pieces), 32'(e[2:0]));
            check("split latency", 32'(lat), 32'(4 * e[2:0]));
            check("split data", r, w & m);
        end
        $display("test split done");
    endtask : t_split

    task automatic t_kinds();
        logic [31:0] r;
        for (int k = 0; k < 8; k++) begin
            exp_def  = DEFS[k];
            exp_lock = !(k == 1 || k == 3);
            mon_on   = 1'b1;
            op(cycle_kind_t'(k), sz_byte, 32'h20, 32'h5a, r);
            mon_on = 1'b0;
        end
        $display("test kinds done");
    endtask : t_kinds

    task automatic settle_hold(input logic v);
        int t;
        t = 0;
        do begin
            @(negedge core_clk);
            t++;
        end while (hold_granted !== v && t < 20);
        check("hold granted", {31'h0, hold_granted}, {31'h0, v});
        check("strobe in hold", {31'h0, address_strobe_out_n}, 32'h1);
        if (hold_granted !== v) final_report();
    endtask : settle_hold

    task automatic t_hold();
        @(posedge core_clk);
        hold_req <= 1'b1;
        settle_hold(1'b1);
        @(posedge core_clk);
        hold_req <= 1'b0;
        settle_hold(1'b0);
        $display("test hold done");
    endtask : t_hold

    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req_kind = k_mem_rd;
        req_size = sz_byte;
        req_addr = 32'h0;
        req_wdata = 32'h0;
        hold_req = 1'b0;
        waits = 4'h0;
        mon_on = 1'b0;
        exp_def = 3'h0;
        exp_lock = 1'b1;
        t_reset();
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_waits();
        t_split();
        t_kinds();
        t_hold();
        final_report();
    end
endmodule : cpu_bus_cycle_and_halfwidth_adapter_tb_top
